/* shared/vpic_regs.svh */
`ifndef VPIC_REGS_SVH
`define VPIC_REGS_SVH

// Register byte offsets on the Avalon-MM slave.
`define VPIC_OFF_TBASE    8'h00
`define VPIC_OFF_FLAGS    8'h04
`define VPIC_OFF_SRCSEL   8'h08
`define VPIC_OFF_CTRL0    8'h80

// Processor flag word fields.
`define VPIC_FLG_GEN      0
`define VPIC_FLG_DBG      1
`define VPIC_FLG_STK      2
`define VPIC_FLG_THR_LO   8
`define VPIC_FLG_THR_HI   10

// Source select register fields.
`define VPIC_SEL_TWI      0
`define VPIC_SEL_N8       6
`define VPIC_SEL_N9       7

// Per-source control register fields.
`define VPIC_CTL_LVL_HI   2
`define VPIC_CTL_REQ      3

// Vector tables.
`define VPIC_FIX_BASE     20'hFFFDC
`define VPIC_VAR_SIZE     9'h100
`define VPIC_BRK_UNSET    8'hFF
`define VPIC_FIRST_MASK   6'h04
`define VPIC_FIRST_KEEPU  6'h20

// Reset values.
`define VPIC_RST_TBASE    20'h00000
`define VPIC_RST_FLAGS    32'h00000000
`define VPIC_RST_SRCSEL   32'h00000000

`endif

/* shared/vpic_pkg.sv */
package vpic_pkg;

  // Fixed slot order; the enum position is the slot index.
  typedef enum logic [3:0] {
    TRAP_UND,
    TRAP_OVF,
    TRAP_BRK,
    TRAP_ADDR,
    TRAP_STEP,
    TRAP_WDT,
    TRAP_DBC,
    TRAP_NMI,
    TRAP_RESET,
    TRAP_INTN
  } vpic_trap_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_BRKCHK,
    ST_DONE
  } vpic_state_e;

endpackage

/* design/vpic_ctrl.sv */
`timescale 1ns/1ps
`include "vpic_regs.svh"
// Functional notes
// - An accepted request branches to the address held in its vector entry.
// - Fixed table starts at FFFDC, four-byte entries, low byte first.
// - Undefined opcode, overflow and break use the first three fixed slots.
// - Then address match, step, watchdog, debugger, NMI pin, reset on top.
// - Break vector whose low byte is FF falls back to variable entry 0.
// - Variable table is 256 bytes at the base, entries for numbers 0..63.
// - Variable entry address is base plus four times the number.
// - Numbers 4..14 are the listed timer, serial, DMA, key and A-D sources.
// - Numbers 15..20 are serial transmit/receive of channels 2, 0, 1.
// - Numbers 21..31 are timers A0-A4, B0-B2 and external inputs 0-2.
// - Numbers 8 and 9 pick their source by select bits 6 and 7.
// - Channel 2 two-wire mode turns its slots into not-ack and ack.
// - Break and software numbers 0..63 ignore the global enable flag.
// - One global enable flag gates all maskable sources, zero after reset.
// - Hardware sets a request bit and clears it on acceptance.
// - Software may clear a request bit by writing zero; never writes one.
// - Three-bit level per source: zero disables, 1 lowest to 7 highest.
// - Accept only with enable set, request set and level above threshold.
// - Enable, request, level and threshold are stored independently.
// - Request and level sit in the source's control register.
// - Maskable gating never applies to reset, NMI, watchdog or traps.
// - Threshold 7 blocks all maskable; threshold n admits n+1 and up.
// - Acceptance loads the threshold with the accepted level.
// - Acceptance clears enable, debug and stack flags; 32..63 keep stack.
module vpic_ctrl (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic [31:4] periphReq,
  input  wire logic [3:0]  altReq,
  input  wire logic        nmiPinN,
  input  wire logic        trapReq,
  input  wire logic [3:0]  trapKind,
  input  wire logic [5:0]  swNum,
  output logic             trapReady,
  output logic             vecRd,
  output logic      [19:0] vecAddr,
  input  wire logic [31:0] vecRdData,
  output logic             branchValid,
  output logic      [19:0] branchAddr,
  output logic      [5:0]  acceptNum
);

  function automatic logic [19:0] fixSlot(input logic [3:0] k);
    fixSlot = `VPIC_FIX_BASE + {14'h0000, k, 2'h0};
  endfunction

  function automatic logic [19:0] varSlot(input logic [19:0] b,
                                          input logic [5:0]  n);
    varSlot = b + {12'h000, n, 2'h0};
  endfunction

  logic [19:0] tbase_r;
  logic [31:0] flags_r;
  logic [31:0] srcsel_r;
  logic [2:0]  lvl_r [4:31];
  logic [31:4] req_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        nmiS1_r;
  logic        nmiS2_r;
  logic        nmiOld_r;
  logic        nmiPend_r;
  logic        rstPend_r;
  logic        trapPend_r;
  logic [3:0]  trapKind_r;
  logic [5:0]  swNum_r;
  vpic_pkg::vpic_state_e state_r;
  logic        brk_r;
  logic [5:0]  num_r;
  logic [19:0] vaddr_r;
  logic        vrd_r;
  logic [19:0] baddr_r;
  logic        bval_r;

  wire       busReq   = read | write;
  wire       busDo    = busReq & ~ack_r;
  // Writes land on the answer edge, where the master sees waitrequest low.
  wire       wrDo     = write & ack_r;
  wire       selTbase = address == `VPIC_OFF_TBASE;
  wire       selFlags = address == `VPIC_OFF_FLAGS;
  wire       selSrc   = address == `VPIC_OFF_SRCSEL;
  wire       selCtl   = address[7] & (address[1:0] == 2'h0);
  wire [4:0] ctlIdx   = address[6:2];
  wire       ctlOk    = selCtl & (ctlIdx >= 5'h04);
  wire       gEn      = flags_r[`VPIC_FLG_GEN];
  wire [2:0] thr      = flags_r[`VPIC_FLG_THR_HI:`VPIC_FLG_THR_LO];
  wire       idle     = state_r == vpic_pkg::ST_IDLE;

  // A second cycle always answers, so the slave never stalls longer.
  assign waitrequest = busReq & ~ack_r;

  // Alternate sources for the shared slots.
  logic [31:4] srcEvt;
  always_comb begin
    srcEvt = periphReq;
    if (srcsel_r[`VPIC_SEL_N8]) srcEvt[8] = altReq[0];
    if (srcsel_r[`VPIC_SEL_N9]) srcEvt[9] = altReq[1];
    if (srcsel_r[`VPIC_SEL_TWI]) begin
      srcEvt[15] = altReq[2];
      srcEvt[16] = altReq[3];
    end
  end

  // Best eligible maskable source; strict compare keeps ties on the lowest.
  logic       bestHit;
  logic [4:0] bestIdx;
  logic [2:0] bestLvl;
  always_comb begin
    bestHit = 1'b0;
    bestIdx = 5'h04;
    bestLvl = 3'h0;
    for (int i = 4; i < 32; i++) begin
      if (req_r[i] && lvl_r[i] > thr &&
          (!bestHit || lvl_r[i] > bestLvl)) begin
        bestHit = 1'b1;
        bestIdx = 5'(i);
        bestLvl = lvl_r[i];
      end
    end
  end

  wire takeRst  = idle & rstPend_r;
  wire takeNmi  = idle & ~rstPend_r & nmiPend_r;
  wire takeTrap = idle & ~rstPend_r & ~nmiPend_r & trapPend_r;
  wire takeMask = idle & ~rstPend_r & ~nmiPend_r & ~trapPend_r
                  & gEn & bestHit;
  wire takeAny  = takeRst | takeNmi | takeTrap | takeMask;
  wire trapIsSw = trapKind_r == 4'(vpic_pkg::TRAP_INTN);
  wire keepStk  = takeTrap & trapIsSw & (swNum_r >= `VPIC_FIRST_KEEPU);

  logic [19:0] takeAddr;
  logic [5:0]  takeNum;
  always_comb begin
    takeNum = 6'h00;
    if (takeRst)
      takeAddr = fixSlot(4'(vpic_pkg::TRAP_RESET));
    else if (takeNmi)
      takeAddr = fixSlot(4'(vpic_pkg::TRAP_NMI));
    else if (takeTrap && trapIsSw) begin
      takeAddr = varSlot(tbase_r, swNum_r);
      takeNum  = swNum_r;
    end else if (takeTrap)
      takeAddr = fixSlot(trapKind_r);
    else begin
      takeAddr = varSlot(tbase_r, {1'b0, bestIdx});
      takeNum  = {1'b0, bestIdx};
    end
  end

  wire brkLow = vecRdData[7:0] == `VPIC_BRK_UNSET;

  assign readdata    = rdata_r;
  assign trapReady   = ~trapPend_r;
  assign vecRd       = vrd_r;
  assign vecAddr     = vaddr_r;
  assign branchValid = bval_r;
  assign branchAddr  = baddr_r;
  assign acceptNum   = num_r;

  logic [31:0] rdNxt;
  always_comb begin
    rdNxt = 32'h00000000;
    if (selTbase) rdNxt = {12'h000, tbase_r};
    else if (selFlags) rdNxt = flags_r;
    else if (selSrc) rdNxt = srcsel_r;
    else if (ctlOk) rdNxt = {28'h0000000, req_r[ctlIdx], lvl_r[ctlIdx]};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r   <= busDo;
      rdata_r <= (read & ~ack_r) ? rdNxt : rdata_r;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tbase_r  <= `VPIC_RST_TBASE;
      srcsel_r <= `VPIC_RST_SRCSEL;
    end else if (wrDo && byteenable == 4'hF) begin
      if (selTbase) tbase_r <= writedata[19:0];
      if (selSrc) srcsel_r <= writedata;
    end
  end

  // Acceptance updates the flag word after a same-cycle software write.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_r <= `VPIC_RST_FLAGS;
    end else begin
      if (wrDo && selFlags && byteenable == 4'hF)
        flags_r <= writedata;
      if (takeAny) begin
        flags_r[`VPIC_FLG_GEN] <= 1'b0;
        flags_r[`VPIC_FLG_DBG] <= 1'b0;
        if (!keepStk) flags_r[`VPIC_FLG_STK] <= 1'b0;
      end
      if (takeMask)
        flags_r[`VPIC_FLG_THR_HI:`VPIC_FLG_THR_LO] <= bestLvl;
    end
  end

  // Hardware set wins over both the software clear and acceptance.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req_r <= '0;
      for (int i = 4; i < 32; i++) lvl_r[i] <= 3'h0;
    end else begin
      for (int i = 4; i < 32; i++) begin
        if (wrDo && ctlOk && ctlIdx == 5'(i) && byteenable[0]) begin
          lvl_r[i] <= writedata[`VPIC_CTL_LVL_HI:0];
          if (!writedata[`VPIC_CTL_REQ]) req_r[i] <= 1'b0;
        end
        if (takeMask && bestIdx == 5'(i)) req_r[i] <= 1'b0;
        if (srcEvt[i]) req_r[i] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nmiS1_r  <= 1'b1;
      nmiS2_r  <= 1'b1;
      nmiOld_r <= 1'b1;
    end else begin
      nmiS1_r  <= nmiPinN;
      nmiS2_r  <= nmiS1_r;
      nmiOld_r <= nmiS2_r;
    end
  end

  wire nmiFall = nmiOld_r & ~nmiS2_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nmiPend_r  <= 1'b0;
      rstPend_r  <= 1'b1;
      trapPend_r <= 1'b0;
      trapKind_r <= 4'h0;
      swNum_r    <= 6'h00;
    end else begin
      rstPend_r <= rstPend_r & ~takeRst;
      nmiPend_r <= nmiFall | (nmiPend_r & ~takeNmi);
      if (takeTrap) trapPend_r <= 1'b0;
      if (trapReq && !trapPend_r) begin
        trapPend_r <= 1'b1;
        trapKind_r <= trapKind;
        swNum_r    <= swNum;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= vpic_pkg::ST_IDLE;
      vrd_r   <= 1'b0;
      vaddr_r <= 20'h00000;
      baddr_r <= 20'h00000;
      bval_r  <= 1'b0;
      brk_r   <= 1'b0;
      num_r   <= 6'h00;
    end else begin
      vrd_r  <= 1'b0;
      bval_r <= 1'b0;
      case (state_r)
        vpic_pkg::ST_IDLE: begin
          if (takeAny) begin
            vaddr_r <= takeAddr;
            vrd_r   <= 1'b1;
            num_r   <= takeNum;
            brk_r   <= takeTrap &
                       (trapKind_r == 4'(vpic_pkg::TRAP_BRK));
            state_r <= vpic_pkg::ST_FETCH;
          end
        end
        vpic_pkg::ST_FETCH: begin
          if (brk_r && brkLow) begin
            vaddr_r <= varSlot(tbase_r, 6'h00);
            vrd_r   <= 1'b1;
            brk_r   <= 1'b0;
            state_r <= vpic_pkg::ST_BRKCHK;
          end else begin
            baddr_r <= vecRdData[19:0];
            bval_r  <= 1'b1;
            state_r <= vpic_pkg::ST_DONE;
          end
        end
        vpic_pkg::ST_BRKCHK: begin
          baddr_r <= vecRdData[19:0];
          bval_r  <= 1'b1;
          state_r <= vpic_pkg::ST_DONE;
        end
        vpic_pkg::ST_DONE: state_r <= vpic_pkg::ST_IDLE;
        default: state_r <= vpic_pkg::ST_IDLE;
      endcase
    end
  end

  thr_block_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (thr == 3'h7 && !rstPend_r) |-> !takeMask)
    else $error("Maskable taken at threshold seven.");

  gen_gate_a: assert property (
    @(posedge clk) disable iff (!rstn)
    takeMask |-> gEn && req_r[bestIdx] && lvl_r[bestIdx] > thr)
    else $error("Maskable taken without enable or level.");

  req_clear_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (takeMask && !srcEvt[bestIdx]) |=> !req_r[$past(bestIdx)])
    else $error("Request bit not cleared on acceptance.");

  req_set_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (srcEvt != 28'h0000000) |=> (req_r & $past(srcEvt)) == $past(srcEvt))
    else $error("Request event did not set its bit.");

  thr_load_a: assert property (
    @(posedge clk) disable iff (!rstn)
    takeMask |=> thr == $past(bestLvl))
    else $error("Threshold not loaded with accepted level.");

  flag_clear_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (takeAny && !keepStk) |=> !flags_r[`VPIC_FLG_GEN]
      && !flags_r[`VPIC_FLG_DBG] && !flags_r[`VPIC_FLG_STK])
    else $error("Enable or stack flag survived acceptance.");

  stk_keep_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (keepStk && !(wrDo && selFlags)) |=>
      flags_r[`VPIC_FLG_STK] == $past(flags_r[`VPIC_FLG_STK]))
    else $error("Stack flag changed for a high software number.");

  var_addr_a: assert property (
    @(posedge clk) disable iff (!rstn)
    takeMask |=> vrd_r && vaddr_r ==
      $past(tbase_r) + {13'h0000, $past(bestIdx), 2'h0})
    else $error("Variable vector address wrong.");

  rst_slot_a: assert property (
    @(posedge clk) disable iff (!rstn)
    takeRst |=> vaddr_r == 20'hFFFFC)
    else $error("Reset vector slot wrong.");

  nmi_slot_a: assert property (
    @(posedge clk) disable iff (!rstn)
    takeNmi |=> vrd_r && vaddr_r == 20'hFFFF8)
    else $error("Pin vector slot wrong.");

  vec_data_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (state_r == vpic_pkg::ST_FETCH && !(brk_r && brkLow)) |=>
      bval_r && baddr_r == $past(vecRdData[19:0]))
    else $error("Branch target differs from fetched entry.");

  brk_fall_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (state_r == vpic_pkg::ST_FETCH && brk_r && brkLow)
      |=> vrd_r && vaddr_r == $past(tbase_r) ##1 bval_r ##1 !bval_r)
    else $error("Break fallback fetch wrong.");

  sw_clear_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (wrDo && ctlOk && byteenable[0] && !writedata[`VPIC_CTL_REQ]
     && ctlIdx >= 5'h04 && !srcEvt[ctlIdx]) |=> !req_r[$past(ctlIdx)])
    else $error("Software clear of request ignored.");

endmodule

/* tb/vpic_vec_mem.sv */
`timescale 1ns/1ps
module vpic_vec_mem (
  input  wire logic        clk,
  input  wire logic        vecRd,
  input  wire logic [19:0] vecAddr,
  input  wire logic        brkUnset,
  output logic      [31:0] vecRdData
);
  logic [31:0] entry;
  logic [31:0] lastWord_r;

  // Each entry encodes its own location, so a wrong fetch shows as a wrong
  // branch target. The controller takes the word in the cycle its fetch
  // strobe is high, so the entry is answered without a register.
  assign entry = (brkUnset && vecAddr == 20'hFFFE4)
                 ? 32'h000000FF
                 : {12'h000, vecAddr ^ 20'h0F0F0};

  always_ff @(posedge clk) begin
    if (vecRd) begin
      lastWord_r <= entry;
    end
  end

  // Between fetches the data lines carry nothing valid.
  assign vecRdData = vecRd ? entry : ~lastWord_r;
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam logic [19:0] TBASE = 20'h12300;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0]  byteenable = 4'hF;
  logic [31:4] periphReq = 28'h0000000;
  logic [3:0]  altReq = 4'h0;
  logic        nmiPinN = 1'b1;
  logic        trapReq = 1'b0;
  logic [3:0]  trapKind = 4'h0;
  logic [5:0]  swNum = 6'h00;
  logic        brkUnset = 1'b0;
  logic        waitrequest, trapReady, vecRd, branchValid;
  logic [19:0] vecAddr, branchAddr;
  logic [31:0] readdata, vecRdData, rd;
  logic [5:0]  acceptNum;
  int          fail_count = 0;
  int          samples_checked = 0;

  always #2.5 clk = ~clk;

  vpic_ctrl u_vpic_ctrl (
    .clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .periphReq(periphReq), .altReq(altReq), .nmiPinN(nmiPinN),
    .trapReq(trapReq), .trapKind(trapKind), .swNum(swNum),
    .trapReady(trapReady), .vecRd(vecRd), .vecAddr(vecAddr),
    .vecRdData(vecRdData), .branchValid(branchValid),
    .branchAddr(branchAddr), .acceptNum(acceptNum));

  vpic_vec_mem u_vpic_vec_mem (
    .clk(clk), .vecRd(vecRd), .vecAddr(vecAddr), .brkUnset(brkUnset),
    .vecRdData(vecRdData));

  task automatic chk(input string name, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic timeout(input string name);
    fail_count++;
    $display("CHECK FAILED %s expected answer seen timeout", name);
    stop_test();
  endtask

  // One Avalon access; the request stands until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 20) timeout("waitrequest");
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk("readdata", rd, exp);
  endtask

  task automatic br(input logic [19:0] a, input logic [5:0] n);
    int i;
    for (i = 0; i < 30; i++) begin
      @(posedge clk);
      if (branchValid === 1'b1) break;
    end
    if (i == 30) timeout("branchValid");
    chk("branchAddr", {12'h000, branchAddr}, {12'h000, a ^ 20'h0F0F0});
    chk("acceptNum", {26'h0000000, acceptNum}, {26'h0000000, n});
  endtask

  // No acceptance may happen in this window.
  task automatic nb();
    repeat (12) begin
      @(posedge clk);
      chk("branchValid", {31'h00000000, branchValid}, 32'h00000000);
    end
  endtask

  task automatic tr(input logic [3:0] k, input logic [5:0] n);
    chk("trapReady", {31'h00000000, trapReady}, 32'h00000001);
    trapReq <= 1'b1;
    trapKind <= k;
    swNum <= n;
    @(posedge clk);
    trapReq <= 1'b0;
  endtask

  task automatic pl(input logic [31:4] m, input logic [3:0] a);
    periphReq <= m;
    altReq <= a;
    @(posedge clk);
    periphReq <= 28'h0000000;
    altReq <= 4'h0;
    @(posedge clk);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    br(20'hFFFFC, 6'h00);
    rc(8'h04, 32'h00000000);
    bus(1'b1, 8'h00, {12'h000, TBASE});
    rc(8'h00, {12'h000, TBASE});
    rc(8'h40, 32'h00000000);
    for (int k = 0; k < 7; k++) begin
      tr(4'(k), 6'h00);
      br(20'hFFFDC + 20'(k * 4), 6'h00);
    end
    brkUnset <= 1'b1;
    tr(4'h2, 6'h00);
    br(TBASE, 6'h00);
    brkUnset <= 1'b0;
    nmiPinN <= 1'b0;
    br(20'hFFFF8, 6'h00);
    nmiPinN <= 1'b1;
    bus(1'b1, 8'h04, 32'h00000004);
    tr(4'h9, 6'h3F);
    br(TBASE + 20'h000FC, 6'h3F);
    rc(8'h04, 32'h00000004);
    tr(4'h9, 6'h11);
    br(TBASE + 20'h00044, 6'h11);
    rc(8'h04, 32'h00000000);
    bus(1'b1, 8'hD4, 32'h00000003);
    pl(28'h0020000, 4'h0);
    rc(8'hD4, 32'h0000000B);
    nb();
    rc(8'h04, 32'h00000000);
    bus(1'b1, 8'h04, 32'h00000205);
    br(TBASE + 20'h00054, 6'h15);
    rc(8'hD4, 32'h00000003);
    rc(8'h04, 32'h00000300);
    bus(1'b1, 8'h90, 32'h00000003);
    pl(28'h0000001, 4'h0);
    bus(1'b1, 8'h04, 32'h00000301);
    nb();
    bus(1'b1, 8'h90, 32'h00000007);
    rc(8'h90, 32'h00000007);
    bus(1'b1, 8'h04, 32'h00000701);
    pl(28'h0000001, 4'h0);
    nb();
    bus(1'b1, 8'h04, 32'h00000601);
    br(TBASE + 20'h00010, 6'h04);
    bus(1'b1, 8'h94, 32'h00000000);
    pl(28'h0000002, 4'h0);
    bus(1'b1, 8'h04, 32'h00000001);
    nb();
    bus(1'b1, 8'h04, 32'h00000000);
    bus(1'b1, 8'h94, 32'h00000004);
    bus(1'b1, 8'h98, 32'h00000004);
    pl(28'h0000006, 4'h0);
    bus(1'b1, 8'h04, 32'h00000001);
    br(TBASE + 20'h00014, 6'h05);
    rc(8'h98, 32'h0000000C);
    bus(1'b1, 8'h04, 32'h00000001);
    br(TBASE + 20'h00018, 6'h06);
    bus(1'b1, 8'h08, 32'h00000041);
    bus(1'b1, 8'hA0, 32'h00000001);
    pl(28'h0000000, 4'h1);
    bus(1'b1, 8'h04, 32'h00000001);
    br(TBASE + 20'h00020, 6'h08);
    bus(1'b1, 8'hBC, 32'h00000001);
    pl(28'h0000000, 4'h4);
    bus(1'b1, 8'h04, 32'h00000001);
    br(TBASE + 20'h0003C, 6'h0F);
    stop_test();
  end
endmodule
